// >>> include/udw_pkg.sv
package udw_pkg;
	// ==========================================================
	// wiper code range
	localparam int WIPER_W = 6;
	localparam logic [5:0] WIPER_MIN = 6'h00;
	localparam logic [5:0] WIPER_MAX = 6'h3f;
	localparam logic [5:0] WIPER_DEFAULT = 6'h1f;
	// ==========================================================
	// pin timing, in ns, and derived cycle counts at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETUP_NS = 500;
	localparam int STEP_HALF_NS = 500;
	localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] HALF_CYC = 8'((STEP_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// ==========================================================
	// command variants
	typedef enum logic [2:0]
	{
		UDW_CMD_INC,
		UDW_CMD_INC_COMPAT,
		UDW_CMD_DEC,
		UDW_CMD_DEC_COMPAT,
		UDW_CMD_HV_INC1,
		UDW_CMD_HV_INC2,
		UDW_CMD_HV_DEC1,
		UDW_CMD_HV_DEC2
	} udw_cmd_t;
endpackage

// >>> logic/udw_tick.sv
`timescale 1ns/100ps
// ==========================================================
// divider: one-cycle enable pulse every HALF_CYC cycles
module udw_tick
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic run,
	output logic tick
);
	import udw_pkg::*;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic tick_nxt;

	// restart count whenever idle so phases line up with commands
	always_comb
	begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (!run)
			cnt_nxt = 8'h00;
		else if (cnt_r == HALF_CYC - 8'h01)
		begin
			cnt_nxt = 8'h00;
			tick_nxt = 1'b1;
		end
		else
			cnt_nxt = cnt_r + 8'h01;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			cnt_r <= 8'h00;
			tick <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			tick <= tick_nxt;
		end
	end
endmodule

// >>> logic/udw_host.sv
`timescale 1ns/100ps
// ==========================================================
// host controller for an up/down stepped wiper
module udw_host
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cmd_valid,
	input udw_pkg::udw_cmd_t cmd_kind,
	input wire logic [5:0] cmd_steps,
	input wire logic dev_reloaded,
	output logic cmd_ready,
	output logic cmd_done,
	output logic [5:0] wiper_shadow,
	output logic sel_n,
	output logic sel_hv,
	output logic step_dir
);
	import udw_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_OPEN, S_LOW, S_HIGH, S_TAIL, S_CLOSE} udw_state_t;

	udw_state_t st_r, st_nxt;
	udw_cmd_t kind_r, kind_nxt;
	logic [5:0] left_r, left_nxt;
	logic [5:0] shadow_r, shadow_nxt;
	logic sel_n_r, sel_n_nxt;
	logic sel_hv_r, sel_hv_nxt;
	logic step_r, step_nxt;
	logic ready_r, ready_nxt;
	logic done_r, done_nxt;
	logic tick;

	// direction of a command: true when it moves toward terminal A
	function automatic logic is_up(input udw_cmd_t k);
		is_up = (k == UDW_CMD_INC) || (k == UDW_CMD_INC_COMPAT) ||
			(k == UDW_CMD_HV_INC1) || (k == UDW_CMD_HV_INC2);
	endfunction

	// level the step pin must hold before sel_n returns high or sel_hv falls
	function automatic logic tail_level(input udw_cmd_t k);
		case (k)
			UDW_CMD_INC_COMPAT: tail_level = 1'b0;
			UDW_CMD_DEC: tail_level = 1'b0;
			UDW_CMD_DEC_COMPAT: tail_level = 1'b1;
			UDW_CMD_HV_INC1: tail_level = 1'b1;
			UDW_CMD_HV_INC2: tail_level = 1'b0;
			UDW_CMD_HV_DEC1: tail_level = 1'b0;
			UDW_CMD_HV_DEC2: tail_level = 1'b1;
			default: tail_level = 1'b1;
		endcase
	endfunction

	// saturating one-code move of the shadow, mirroring the device
	function automatic logic [5:0] step_code(input logic [5:0] c, input logic up);
		if (up)
			step_code = (c == WIPER_MAX) ? c : c + 6'h01;
		else
			step_code = (c == WIPER_MIN) ? c : c - 6'h01;
	endfunction

	udw_tick u_tick
	(
		.clk_sys(clk_sys),
		.rstn(rstn),
		.run(st_r != S_IDLE),
		.tick(tick)
	);

	// ==========================================================
	// command sequencer
	always_comb
	begin
		st_nxt = st_r;
		kind_nxt = kind_r;
		left_nxt = left_r;
		shadow_nxt = shadow_r;
		sel_n_nxt = sel_n_r;
		sel_hv_nxt = sel_hv_r;
		step_nxt = step_r;
		ready_nxt = ready_r;
		done_nxt = 1'b0;
		case (st_r)
			S_IDLE:
			begin
				sel_n_nxt = 1'b1;
				sel_hv_nxt = 1'b0;
				ready_nxt = 1'b1;
				if (cmd_valid && ready_r)
				begin
					kind_nxt = cmd_kind;
					left_nxt = cmd_steps;
					step_nxt = is_up(cmd_kind);
					ready_nxt = 1'b0;
					st_nxt = S_SETUP;
				end
			end
			S_SETUP:
				if (tick)
				begin
					if (kind_r inside {UDW_CMD_HV_INC1, UDW_CMD_HV_INC2,
						UDW_CMD_HV_DEC1, UDW_CMD_HV_DEC2})
						sel_hv_nxt = 1'b1;
					else
						sel_n_nxt = 1'b0;
					st_nxt = S_OPEN;
				end
			S_OPEN:
				// drop step low so each pulse yields one rising edge
				if (tick)
				begin
					step_nxt = 1'b0;
					st_nxt = (left_r == 6'h00) ? S_TAIL : S_LOW;
				end
			S_LOW:
				if (tick)
				begin
					step_nxt = 1'b1;
					left_nxt = left_r - 6'h01;
					shadow_nxt = step_code(shadow_r, is_up(kind_r));
					st_nxt = S_HIGH;
				end
			S_HIGH:
				if (tick)
				begin
					if (left_r != 6'h00)
					begin
						step_nxt = 1'b0;
						st_nxt = S_LOW;
					end
					else
					begin
						step_nxt = tail_level(kind_r);
						st_nxt = S_TAIL;
					end
				end
			S_TAIL:
				// tail may only pull step low; a zero-step command must see no rising edge,
				// so a high tail after zero steps is given up to keep the wiper still
				if (tick)
				begin
					step_nxt = step_r & tail_level(kind_r);
					st_nxt = S_CLOSE;
				end
			S_CLOSE:
				if (tick)
				begin
					sel_n_nxt = 1'b1;
					sel_hv_nxt = 1'b0;
					done_nxt = 1'b1;
					ready_nxt = 1'b1;
					st_nxt = S_IDLE;
				end
			default:
				st_nxt = S_IDLE;
		endcase
		if (dev_reloaded)
			shadow_nxt = WIPER_DEFAULT;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			st_r <= S_IDLE;
			kind_r <= UDW_CMD_INC;
			left_r <= 6'h00;
			shadow_r <= WIPER_DEFAULT;
			sel_n_r <= 1'b1;
			sel_hv_r <= 1'b0;
			step_r <= 1'b0;
			ready_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			kind_r <= kind_nxt;
			left_r <= left_nxt;
			shadow_r <= shadow_nxt;
			sel_n_r <= sel_n_nxt;
			sel_hv_r <= sel_hv_nxt;
			step_r <= step_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
		end
	end

	assign sel_n = sel_n_r;
	assign sel_hv = sel_hv_r;
	assign step_dir = step_r;
	assign cmd_ready = ready_r;
	assign cmd_done = done_r;
	assign wiper_shadow = shadow_r;
endmodule

// >>> verif/udw_host_properties.sv
`timescale 1ns/100ps
// ==========================================================
// pin-level checks on the host
module udw_host_chk
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic dev_reloaded,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic [5:0] wiper_shadow,
	input wire logic sel_n,
	input wire logic sel_hv,
	input wire logic step_dir
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// a request accepted, and a select opening or closing
	sequence s_take; cmd_valid && cmd_ready; endsequence
	sequence s_open; $fell(sel_n) || $rose(sel_hv); endsequence
	sequence s_close; $rose(sel_n) || $fell(sel_hv); endsequence
	sel_idle_a: assert property (cmd_ready |-> sel_n && !sel_hv) else $error("open while idle");
	one_level_a: assert property (sel_n || !sel_hv) else $error("both levels");
	take_busy_a: assert property (s_take |=> !cmd_ready && sel_n) else $error("take");
	close_done_a: assert property (s_close |-> cmd_done && cmd_ready) else $error("close");
	done_once_a: assert property (cmd_done |=> !cmd_done) else $error("done width");
	dir_setup_a: assert property (s_open |-> $stable(step_dir)) else $error("dir setup");
	reload_a: assert property (dev_reloaded |=> wiper_shadow == 6'h1f) else $error("reload");
	reset_val_a: assert property ($rose(rstn) |-> sel_n && !step_dir && wiper_shadow == 6'h1f)
		else $error("reset state");
endmodule
bind udw_host udw_host_chk udw_host_chk_i (.*);

// >>> verif/udw_dev.sv
`timescale 1ns/100ps
// ==========================================================
// behavioural wiper device; wiper is for the bench only
module udw_dev
(
	input wire logic por,
	input wire logic sel_n,
	input wire logic sel_hv,
	input wire logic step_dir,
	output logic [5:0] wiper
);
	import udw_pkg::*;
	logic up;
	always @(negedge sel_n or posedge sel_hv)
		up = step_dir;
	always @(posedge step_dir)
		if (!sel_n || sel_hv)
			wiper = up ? wiper + 6'(wiper != WIPER_MAX) : wiper - 6'(wiper != WIPER_MIN);
	// reload, no read path to host
	always @(posedge por)
		wiper = WIPER_DEFAULT;
endmodule

// >>> verif/tb_udw_host.sv
`timescale 1ns/100ps
// ==========================================================
// bench: rows of commands, then mid-run reset and brown-out
module tb_udw_host;
	import udw_pkg::*;
	typedef struct {udw_cmd_t k; logic [5:0] n; logic [5:0] w;} udw_row_t;
	logic clk_sys = 0, rstn = 0, cmd_valid = 0, dev_reloaded = 0, por = 0;
	udw_cmd_t cmd_kind = UDW_CMD_INC;
	logic [5:0] cmd_steps = 6'h00;
	logic cmd_ready, cmd_done, sel_n, sel_hv, step_dir;
	logic [5:0] wiper_shadow, wiper;
	int miscompares = 0, comparisons = 0;
	// last rows run into both ends of the range
	udw_row_t rows[12] = '{'{UDW_CMD_INC, 6'h03, 6'h22}, '{UDW_CMD_INC_COMPAT, 6'h02, 6'h24},
		'{UDW_CMD_DEC, 6'h04, 6'h20}, '{UDW_CMD_DEC_COMPAT, 6'h01, 6'h1f},
		'{UDW_CMD_HV_INC1, 6'h02, 6'h21}, '{UDW_CMD_HV_INC2, 6'h01, 6'h22},
		'{UDW_CMD_HV_DEC1, 6'h02, 6'h20}, '{UDW_CMD_HV_DEC2, 6'h00, 6'h20},
		'{UDW_CMD_INC, 6'h3f, 6'h3f}, '{UDW_CMD_HV_INC1, 6'h01, 6'h3f},
		'{UDW_CMD_DEC, 6'h3f, 6'h00}, '{UDW_CMD_HV_DEC1, 6'h01, 6'h00}};
	always #5 clk_sys = ~clk_sys;
	udw_host udw_host_i (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_steps(cmd_steps), .dev_reloaded(dev_reloaded),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done), .wiper_shadow(wiper_shadow),
		.sel_n(sel_n), .sel_hv(sel_hv), .step_dir(step_dir));
	udw_dev udw_dev_i (.por(por), .sel_n(sel_n), .sel_hv(sel_hv), .step_dir(step_dir),
		.wiper(wiper));
	task summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [5:0] got, input logic [5:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one command, held until taken, then wait for the close
	task run(input udw_cmd_t k, input logic [5:0] n);
		int t;
		t = 0;
		while (cmd_ready !== 1'b1)
		begin
			@(posedge clk_sys);
			#1;
		end
		cmd_kind = k;
		cmd_steps = n;
		cmd_valid = 1;
		@(posedge clk_sys);
		#1 cmd_valid = 0;
		while (cmd_done !== 1'b1 && t < 8000)
		begin
			@(posedge clk_sys);
			#1 t++;
		end
		// a command that never closes counts against the run
		if (t >= 8000)
		begin
			miscompares++;
			$display("unexpected at %0t: command not closed", $time);
		end
	endtask
	// a hang ends the run as a failure
	initial
	begin
		#300000 miscompares++;
		summarize;
	end
	initial
	begin
		#1 por = 1;
		#1 por = 0;
		repeat (10) @(posedge clk_sys);
		#1 rstn = 1;
		repeat (3) @(posedge clk_sys);
		#1 chk(wiper_shadow, WIPER_DEFAULT);
		chk({2'h0, sel_n, sel_hv, step_dir, cmd_ready}, 6'h09);
		$display("test reset done");
		foreach (rows[i])
		begin
			run(rows[i].k, rows[i].n);
			chk(wiper, rows[i].w);
			chk(wiper_shadow, rows[i].w);
			$display("test row %0d done", i);
		end
		// reset in mid-command: pins fall back to idle on the next clock edge
		cmd_kind = UDW_CMD_INC;
		cmd_steps = 6'h04;
		cmd_valid = 1;
		@(posedge clk_sys);
		#1 cmd_valid = 0;
		repeat (120) @(posedge clk_sys);
		#1 rstn = 0;
		repeat (10) @(posedge clk_sys);
		#1 chk({2'h0, sel_n, sel_hv, step_dir, cmd_ready}, 6'h08);
		rstn = 1;
		repeat (3) @(posedge clk_sys);
		#1 chk({2'h0, sel_n, sel_hv, step_dir, cmd_ready}, 6'h09);
		chk(wiper_shadow, WIPER_DEFAULT);
		$display("test mid-run reset done");
		por = 1;
		dev_reloaded = 1;
		@(posedge clk_sys);
		#1 por = 0;
		dev_reloaded = 0;
		@(posedge clk_sys);
		#1 chk(wiper, WIPER_DEFAULT);
		chk(wiper_shadow, WIPER_DEFAULT);
		$display("test brown-out done");
		summarize;
	end
endmodule
